// *** dio_pkg.sv ***
// shared constants, source codes and carriers for the digital i/o block
package dio_pkg;
    localparam int          N_OUT         = 4;
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          SAMPLE_MS     = 1;
    localparam int          SAMPLE_CYCLES =
        (SAMPLE_MS * 1000000) / CLK_PERIOD_NS;
    localparam int          TICK_W        = $clog2(SAMPLE_CYCLES);
    localparam int          BLINK_MS      = 500;
    localparam int          BLINK_TICKS   = BLINK_MS / SAMPLE_MS;
    localparam int          BLINK_W       = 10;
    // register byte addresses, output table address fields and led reset value
    localparam logic [7:0]  A_IN_SPEC     = 8'h00;
    localparam logic [7:0]  A_IN_INV      = 8'h04;
    localparam logic [7:0]  A_IN_FEN      = 8'h08;
    localparam logic [7:0]  A_IN_FVAL     = 8'h0C;
    localparam logic [7:0]  A_IN_RAW      = 8'h10;
    localparam logic [7:0]  A_IN_REN      = 8'h14;
    localparam logic [7:0]  A_DIN_WORD    = 8'h18;
    localparam logic [7:0]  A_DOUT_WORD   = 8'h1C;
    localparam logic [7:0]  A_OUT_INV     = 8'h20;
    localparam logic [7:0]  A_MAN_EN      = 8'h24;
    localparam logic [7:0]  A_MAN_VAL     = 8'h28;
    localparam logic [7:0]  A_READBACK    = 8'h2C;
    localparam logic [7:0]  A_OUT_REN     = 8'h30;
    localparam logic [7:0]  A_LED_CTRL    = 8'h34;
    localparam logic [7:0]  A_STATUS      = 8'h38;
    localparam logic [1:0]  A_OTAB_HI     = 2'h1;
    localparam logic [1:0]  A_OTAB_MID    = 2'h0;
    localparam logic [1:0]  LED_RST       = 2'h3;
    // input source codes
    localparam int          INV_BIT       = 7;
    localparam logic [6:0]  C_PHYS_LAST   = 7'h10;
    localparam logic [6:0]  C_HALL_U      = 7'h41;
    localparam logic [6:0]  C_HALL_W      = 7'h43;
    localparam logic [6:0]  C_ENC_A       = 7'h44;
    localparam logic [6:0]  C_ENC_IDX     = 7'h46;
    localparam logic [6:0]  C_USB         = 7'h47;
    localparam logic [7:0]  C_INV         = 8'h80;
    // bit positions and output routing
    localparam int          OUT_BIT0      = 16;
    localparam int          BRAKE_BIT     = 0;
    localparam int          INTERLOCK_BIT = 3;
    localparam logic [15:0] ROUTE_OFF     = 16'hFFFF;
    localparam logic [7:0]  OS_ONE        = 8'h00;
    localparam logic [7:0]  OS_ZERO       = 8'h01;
    localparam logic [7:0]  OS_PWM        = 8'h10;
    localparam logic [7:0]  OS_PWM_N      = 8'h11;

    typedef struct packed {
        logic        usb;
        logic [2:0]  enc;
        logic [2:0]  hall;
        logic [15:0] phys;
    } src_t;

    // unlisted codes read as zero before the inversion bit
    function automatic logic decode_src(src_t s, logic [7:0] code);
        logic [6:0] b;
        logic       v;
        b = code[6:0];
        v = 1'b0;
        if (b != 7'h00 && b <= C_PHYS_LAST) begin
            v = s.phys[4'(b - 7'h01)];
        end else if (b >= C_HALL_U && b <= C_HALL_W) begin
            v = s.hall[2'(b - C_HALL_U)];
        end else if (b >= C_ENC_A && b <= C_ENC_IDX) begin
            v = s.enc[2'(b - C_ENC_A)];
        end else if (b == C_USB) begin
            v = s.usb;
        end
        return v ^ code[INV_BIT];
    endfunction : decode_src
endpackage : dio_pkg

// *** din_source_sel.sv ***
// one bit of the routed input word, chosen by its source code
`timescale 1ns/10ps
`default_nettype none
module din_source_sel import dio_pkg::*; (
    input  wire logic [7:0] i_code,
    input  wire src_t       i_src,
    output logic            o_bit
);
    assign o_bit = decode_src(i_src, i_code);
endmodule : din_source_sel
`default_nettype wire

// *** dout_route.sv ***
// one routed output: source in high byte, gate bit index in low byte
`timescale 1ns/10ps
`default_nettype none
module dout_route import dio_pkg::*; (
    input  wire logic [15:0] i_entry,
    input  wire logic [31:0] i_word,
    input  wire logic        i_pwm,
    input  wire logic        i_plain,
    output logic             o_level
);
    logic src;
    logic gate;

    always_comb begin
        unique case (i_entry[15:8])
            OS_ONE:   src = 1'b1;
            OS_ZERO:  src = 1'b0;
            OS_PWM:   src = i_pwm;
            OS_PWM_N: src = ~i_pwm;
            // divided encoder sources are not built here
            default:  src = 1'b0;
        endcase
    end

    assign gate = i_word[i_entry[4:0]] ^ i_entry[INV_BIT];
    assign o_level = (i_entry == ROUTE_OFF) ? i_plain : (src & gate);
endmodule : dout_route
`default_nettype wire

// *** digital_io_routing.sv ***
// digital input/output word handling with input and output routing
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module digital_io_routing import dio_pkg::*; #(
    parameter int TICK_CYCLES = SAMPLE_CYCLES
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst_b,
    input  wire logic [7:0]       i_addr,
    input  wire logic [31:0]      i_wr_data,
    input  wire logic             i_wr,
    input  wire logic             i_rd,
    output logic      [31:0]      o_rd_data,
    input  wire logic [15:0]      i_phys_in,
    input  wire logic [2:0]       i_hall,
    input  wire logic [2:0]       i_enc,
    input  wire logic             i_usb_power,
    input  wire logic             i_pwm,
    output logic                  o_brake,
    output logic      [N_OUT-1:0] o_out,
    output logic                  o_motion_ok,
    output logic                  o_interlock_err,
    output logic                  o_led_green,
    output logic                  o_led_red
);
    typedef struct packed {
        logic [TICK_W-1:0]           tick_cnt;
        logic                        tick;
        logic [BLINK_W-1:0]          led_cnt;
        logic                        blink;
        src_t                        samp;
        logic [15:0]                 in_spec;
        logic [15:0]                 in_inv;
        logic [15:0]                 in_fen;
        logic [15:0]                 in_fval;
        logic                        in_ren;
        logic [31:0][7:0]            in_tab;
        logic [31:0]                 din;
        logic [31:0]                 dout;
        logic [31:0]                 out_inv;
        logic [31:0]                 man_en;
        logic [31:0]                 man_val;
        logic [31:0]                 applied;
        logic                        out_ren;
        logic [N_OUT-1:0][15:0]      out_tab;
        logic [1:0]                  led_ctrl;
        logic                        il_err;
        logic                        led_g;
        logic                        led_r;
        logic [31:0]                 rdata;
    } state_t;

    localparam logic [TICK_W-1:0]  TICK_LAST  = TICK_W'(TICK_CYCLES - 1);
    localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_TICKS - 1);

    state_t           st;
    state_t           next_st;
    logic [31:0]      routed_din;
    logic [31:0]      fixed_din;
    logic [31:0]      fixed_out;
    logic [N_OUT-1:0] routed_out;
    src_t             raw;

    assign raw = '{usb: i_usb_power, enc: i_enc, hall: i_hall,
                   phys: i_phys_in};

    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_din
            din_source_sel u_sel (
                .i_code (st.in_tab[g]),
                .i_src  (st.samp),
                .o_bit  (routed_din[g])
            );
        end
        for (g = 0; g < N_OUT; g++) begin : g_dout
            dout_route u_route (
                .i_entry (st.out_tab[g]),
                .i_word  (st.dout),
                .i_pwm   (i_pwm),
                .i_plain (st.dout[OUT_BIT0 + g]),
                .o_level (routed_out[g])
            );
        end
    endgenerate

    // fixed input mapping: level in upper half, special fn in lower
    always_comb begin
        logic lvl;
        lvl = 1'b0;
        fixed_din = '0;
        for (int i = 0; i < 16; i++) begin
            lvl = st.in_fen[i] ? st.in_fval[i]
                               : (st.samp.phys[i] ^ st.in_inv[i]);
            fixed_din[OUT_BIT0 + i] = lvl;
            fixed_din[i] = st.in_spec[i] & lvl;
        end
    end

    // manual value bypasses inversion; brake is bit 0
    assign fixed_out = (st.man_en & st.man_val)
                     | (~st.man_en & (st.dout ^ st.out_inv));

    always_comb begin
        next_st = st;
        next_st.tick = 1'b0;
        // one millisecond divider for sampling and blinking
        if (st.tick_cnt == TICK_LAST) begin
            next_st.tick_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 1'b1;
        end
        // single sample per tick can miss pulses shorter than a tick
        if (st.tick) begin
            next_st.samp = raw;
            if (st.led_cnt == BLINK_LAST) begin
                next_st.led_cnt = '0;
                next_st.blink = ~st.blink;
            end else begin
                next_st.led_cnt = st.led_cnt + 1'b1;
            end
        end
        next_st.din = st.in_ren ? routed_din : fixed_din;
        // interlock bit keeps working under routing, else unusable
        next_st.il_err = st.in_spec[INTERLOCK_BIT]
                       & ~st.din[INTERLOCK_BIT];
        next_st.applied = st.out_ren ? st.dout : fixed_out;
        if (st.out_ren) begin
            for (int k = 0; k < N_OUT; k++) begin
                next_st.applied[OUT_BIT0 + k] = routed_out[k];
            end
        end
        next_st.led_g = st.led_ctrl[0] & ~st.il_err & st.blink;
        next_st.led_r = st.led_ctrl[1] & st.il_err & st.blink;

        if (i_wr) begin
            if (i_addr[7]) begin
                next_st.in_tab[i_addr[6:2]] = i_wr_data[7:0];
            end else if (i_addr[7:6] == A_OTAB_HI
                         && i_addr[5:4] == A_OTAB_MID) begin
                next_st.out_tab[i_addr[3:2]] = i_wr_data[15:0];
            end else begin
                unique case (i_addr)
                    A_IN_SPEC:   next_st.in_spec = i_wr_data[15:0];
                    A_IN_INV:    next_st.in_inv = i_wr_data[15:0];
                    A_IN_FEN:    next_st.in_fen = i_wr_data[15:0];
                    A_IN_FVAL:   next_st.in_fval = i_wr_data[15:0];
                    A_IN_REN: begin
                        next_st.in_ren = i_wr_data[0];
                        if (i_wr_data[0] && !st.in_ren) begin
                            // rebuild previous behaviour; force is lost
                            for (int i = 0; i < 16; i++) begin
                                next_st.in_tab[OUT_BIT0 + i] =
                                    (st.in_inv[i] ? C_INV : 8'h00)
                                    | 8'(i + 1);
                                next_st.in_tab[i] = st.in_spec[i]
                                    ? next_st.in_tab[OUT_BIT0 + i]
                                    : 8'h00;
                            end
                        end
                    end
                    A_DOUT_WORD: next_st.dout = i_wr_data;
                    A_OUT_INV:   next_st.out_inv = i_wr_data;
                    A_MAN_EN:    next_st.man_en = i_wr_data;
                    A_MAN_VAL:   next_st.man_val = i_wr_data;
                    A_OUT_REN:   next_st.out_ren = i_wr_data[0];
                    A_LED_CTRL:  next_st.led_ctrl = i_wr_data[1:0];
                    default:     next_st.tick = next_st.tick;
                endcase
            end
        end

        next_st.rdata = '0;
        if (i_rd) begin
            if (i_addr[7]) begin
                next_st.rdata[7:0] = st.in_tab[i_addr[6:2]];
            end else if (i_addr[7:6] == A_OTAB_HI
                         && i_addr[5:4] == A_OTAB_MID) begin
                next_st.rdata[15:0] = st.out_tab[i_addr[3:2]];
            end else begin
                unique case (i_addr)
                    A_IN_SPEC:   next_st.rdata[15:0] = st.in_spec;
                    A_IN_INV:    next_st.rdata[15:0] = st.in_inv;
                    A_IN_FEN:    next_st.rdata[15:0] = st.in_fen;
                    A_IN_FVAL:   next_st.rdata[15:0] = st.in_fval;
                    A_IN_RAW:    next_st.rdata[15:0] = st.samp.phys;
                    A_IN_REN:    next_st.rdata[0] = st.in_ren;
                    A_DIN_WORD:  next_st.rdata = st.din;
                    A_DOUT_WORD: next_st.rdata = st.dout;
                    A_OUT_INV:   next_st.rdata = st.out_inv;
                    A_MAN_EN:    next_st.rdata = st.man_en;
                    A_MAN_VAL:   next_st.rdata = st.man_val;
                    A_READBACK:  next_st.rdata = st.applied;
                    A_OUT_REN:   next_st.rdata[0] = st.out_ren;
                    A_LED_CTRL:  next_st.rdata[1:0] = st.led_ctrl;
                    A_STATUS:    next_st.rdata[0] = st.il_err;
                    default:     next_st.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_b) begin
            st <= '0;
            st.out_tab <= {N_OUT{ROUTE_OFF}};
            st.led_ctrl <= LED_RST;
        end else begin
            st <= next_st;
        end
    end

    assign o_rd_data       = st.rdata;
    assign o_brake         = st.applied[BRAKE_BIT];
    assign o_out           = st.applied[OUT_BIT0 +: N_OUT];
    assign o_interlock_err = st.il_err;
    assign o_motion_ok     = ~st.il_err;
    assign o_led_green     = st.led_g;
    assign o_led_red       = st.led_r;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);

    a_reset_routing: assert property (
        disable iff (1'b0) !i_rst_b |=> !st.in_ren && !st.out_ren
            && st.out_tab[0] == ROUTE_OFF)
        else $error("routing not off after reset");
    a_route_load: assert property (
        i_wr && i_addr == A_IN_REN && i_wr_data[0] && !st.in_ren
            |=> st.in_tab[OUT_BIT0 + 1][6:0] == 7'h02
            && st.in_tab[OUT_BIT0][7] == $past(st.in_inv[0]))
        else $error("routing table not loaded on activation");
    a_din_routed: assert property (
        st.in_ren && st.in_tab[8] == C_INV && !(i_wr && i_addr[7])
            |=> st.din[8])
        else $error("constant one source not routed");
    a_sample_hold: assert property (
        !st.tick |=> $stable(st.samp))
        else $error("inputs sampled off the tick");
    a_interlock_err: assert property (
        st.in_spec[INTERLOCK_BIT] && !st.din[INTERLOCK_BIT]
            |=> o_interlock_err && !o_motion_ok)
        else $error("interlock release low without error");
    a_brake_manual: assert property (
        !st.out_ren && st.man_en[BRAKE_BIT]
            |=> o_brake == $past(st.man_val[BRAKE_BIT]))
        else $error("manual brake value not applied");
    a_out_invert: assert property (
        !st.out_ren && !st.man_en[OUT_BIT0] && st.out_inv[OUT_BIT0]
            && st.dout[OUT_BIT0] |=> !o_out[0])
        else $error("inverted output not driven low");
    a_route_off: assert property (
        st.out_ren && st.out_tab[0] == ROUTE_OFF
            |=> o_out[0] == $past(st.dout[OUT_BIT0]))
        else $error("disabled route does not follow word");
    a_route_gate: assert property (
        st.out_ren && st.out_tab[0][15:8] == OS_ONE
            && st.out_tab[0][7:5] == 3'h0
            |=> o_out[0] == $past(st.dout[st.out_tab[0][4:0]]))
        else $error("routed output not gated by word bit");
    a_led_off: assert property (
        !st.led_ctrl[0] |=> !o_led_green)
        else $error("green led on while disabled");
    a_route_pwm: assert property (
        st.out_ren && st.out_tab[1][15:8] == OS_PWM
            && st.out_tab[1][7:5] == 3'h0
            |=> o_out[1] == ($past(i_pwm)
                             & $past(st.dout[st.out_tab[1][4:0]])))
        else $error("pwm source not gated by word bit");

    c_in_route_on: cover property (st.in_ren && st.tick);
    c_interlock:   cover property ($rose(o_interlock_err));
    c_out_routed:  cover property (st.out_ren && $changed(o_out));
endmodule : digital_io_routing
`default_nettype wire

// *** field_side.sv ***
// far-side model: switches, sensors and a pwm line at the pins
`timescale 1ns/10ps
`default_nettype none
module field_side import dio_pkg::*; (
    input  wire logic i_core_clk,
    input  wire src_t i_level,
    output var  src_t o_level,
    output var  logic o_pwm
);
    logic [1:0] div;

    initial begin
        o_level = i_level;
        o_pwm   = 1'b0;
        div     = 2'h0;
    end

    // levels move just after an edge and are then held for many ticks,
    // so no change is shorter than one sample period
    always @(posedge i_core_clk) begin
        o_level <= i_level;
        div     <= div + 2'h1;
        o_pwm   <= div[1];
    end
endmodule : field_side
`default_nettype wire

// *** digital_io_routing_tb.sv ***
// self-checking bench for the digital i/o routing block
`timescale 1ns/10ps
`default_nettype none
module digital_io_routing_tb import dio_pkg::*;;
    logic             clk;
    logic             rst_b;
    logic             wr;
    logic             rd;
    logic [7:0]       addr;
    logic [31:0]      wdata;
    logic [31:0]      rdata;
    logic [31:0]      q;
    logic [31:0]      exp_w;
    src_t             lvl;
    src_t             fld;
    logic             pwm;
    logic             brake;
    logic             motion_ok;
    logic             ilk_err;
    logic             led_g;
    logic             led_r;
    logic [N_OUT-1:0] outs;
    int               fail_count;
    int               check_count;
    logic [7:0]       codes [12] = '{8'h00, 8'h01, 8'h10, 8'h41, 8'h43,
        8'h44, 8'h46, 8'h47, 8'h80, 8'h81, 8'hC7, 8'hC5};

    always #5 clk = ~clk;

    field_side field_side_inst (
        .i_core_clk (clk),
        .i_level    (lvl),
        .o_level    (fld),
        .o_pwm      (pwm)
    );

    // short tick keeps the led blink inside a few thousand cycles
    digital_io_routing #(.TICK_CYCLES(8)) digital_io_routing_inst (
        .i_core_clk      (clk),
        .i_rst_b         (rst_b),
        .i_addr          (addr),
        .i_wr_data       (wdata),
        .i_wr            (wr),
        .i_rd            (rd),
        .o_rd_data       (rdata),
        .i_phys_in       (fld.phys),
        .i_hall          (fld.hall),
        .i_enc           (fld.enc),
        .i_usb_power     (fld.usb),
        .i_pwm           (pwm),
        .o_brake         (brake),
        .o_out           (outs),
        .o_motion_ok     (motion_ok),
        .o_interlock_err (ilk_err),
        .o_led_green     (led_g),
        .o_led_red       (led_r)
    );

    function automatic logic exp_src(logic [7:0] c);
        logic v;
        case (c[6:0]) inside
            [7'h01:7'h10]: v = lvl.phys[c[3:0] - 4'h1];
            [7'h41:7'h43]: v = lvl.hall[c[1:0] - 2'h1];
            [7'h44:7'h46]: v = lvl.enc[c[1:0]];
            7'h47:         v = lvl.usb;
            default:       v = 1'b0;
        endcase
        return v ^ c[7];
    endfunction : exp_src

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string n);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd   <= 1'b0;
        @(posedge clk);
        q = rdata;
        chk(n, e, q);
    endtask : rd_chk

    task automatic out_chk(input logic [31:0] e);
        rd_chk(A_READBACK, e, "readback");
        chk("pins", {27'h0, e[19:16], e[0]}, {27'h0, outs, brake});
    endtask : out_chk

    task automatic ilk(input logic [7:0] c, input logic e);
        wr_reg(8'h8C, {24'h0, c});
        repeat (2) @(posedge clk);
        rd_chk(A_STATUS, {31'h0, e}, "status");
        chk("interlock", {30'h0, ~e, e}, {30'h0, motion_ok, ilk_err});
    endtask : ilk

    // one blink period fits inside the watch window
    task automatic led_watch(input logic [1:0] c, input logic err);
        logic seen_g;
        logic seen_r;
        seen_g = 1'b0;
        seen_r = 1'b0;
        wr_reg(A_LED_CTRL, {30'h0, c});
        repeat (9000) begin
            @(posedge clk);
            seen_g = seen_g | led_g;
            seen_r = seen_r | led_r;
        end
        chk("led_green", {31'h0, c[0] & ~err}, {31'h0, seen_g});
        chk("led_red", {31'h0, c[1] & err}, {31'h0, seen_r});
    endtask : led_watch

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #400000;
        fail_count++;
        $display("MISMATCH watchdog expected end seen timeout");
        print_verdict();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        fail_count = 0;
        check_count = 0;
        lvl = '{usb: 1'b1, enc: 3'b010, hall: 3'b101, phys: 16'hA5C2};
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(A_IN_REN, 32'h0, "in_route_en");
        rd_chk(A_OUT_REN, 32'h0, "out_route_en");
        rd_chk(8'h40, {16'h0, ROUTE_OFF}, "out_entry");
        rd_chk(A_LED_CTRL, {30'h0, LED_RST}, "led_ctrl");
        wr_reg(8'h3C, 32'hFFFF_FFFF);
        rd_chk(8'h3C, 32'h0, "unmapped");
        $display("test reset done");
        wr_reg(A_IN_SPEC, 32'h1);
        wr_reg(A_IN_INV, 32'hF);
        repeat (24) @(posedge clk);
        rd_chk(A_DIN_WORD, 32'hA5CD_0001, "din_fixed");
        // routing switched on once and left on
        wr_reg(A_IN_REN, 32'h1);
        rd_chk(A_DIN_WORD, 32'hA5CD_0001, "din_load");
        wr_reg(A_IN_INV, 32'h0);
        wr_reg(A_IN_FEN, 32'hFFFF);
        wr_reg(A_IN_FVAL, 32'h0);
        rd_chk(A_DIN_WORD, 32'hA5CD_0001, "din_cfg_off");
        exp_w = 32'hA5CD_0000;
        for (int n = 0; n < 12; n++) begin
            wr_reg(8'h80 + 8'(4 * n), {24'h0, codes[n]});
            exp_w[n] = exp_src(codes[n]);
        end
        rd_chk(A_DIN_WORD, exp_w, "din_routed");
        $display("test input routing done");
        wr_reg(A_IN_SPEC, 32'h8);
        ilk(8'h80, 1'b0);
        ilk(8'h00, 1'b1);
        ilk(8'h80, 1'b0);
        $display("test interlock done");
        wr_reg(A_DOUT_WORD, 32'h0005_0001);
        out_chk(32'h0005_0001);
        wr_reg(A_OUT_INV, 32'h0001_0000);
        out_chk(32'h0004_0001);
        wr_reg(A_MAN_EN, 32'h0002_0001);
        wr_reg(A_MAN_VAL, 32'h0002_0000);
        out_chk(32'h0006_0000);
        wr_reg(A_OUT_REN, 32'h1);
        out_chk(32'h0005_0001);
        wr_reg(8'h40, 32'h0005);
        wr_reg(8'h44, 32'h0100);
        wr_reg(8'h48, 32'h0080);
        wr_reg(8'h4C, 32'h0000);
        out_chk(32'h0008_0001);
        wr_reg(A_DOUT_WORD, 32'h0000_0020);
        out_chk(32'h0005_0020);
        wr_reg(8'h40, 32'hFFFF);
        out_chk(32'h0004_0020);
        // pwm source gated by word bit 5, watched by its assertion
        wr_reg(8'h44, 32'h1005);
        repeat (16) @(posedge clk);
        $display("test outputs done");
        led_watch(2'h0, 1'b0);
        led_watch(2'h1, 1'b0);
        ilk(8'h00, 1'b1);
        led_watch(2'h2, 1'b1);
        $display("test led done");
        print_verdict();
    end
endmodule : digital_io_routing_tb
`default_nettype wire
